// ===== bench/calib_guard_chk.sv
// assertion checker for the calibration guard block
`default_nettype none
module calib_guard_chk (
    input wire logic                  REF_CLK_I,
    input wire logic                  RST_N_I,
    input wire logic                  CMD_VALID_I,
    input wire calib_guard_pkg::cmd_t CMD_I,
    input wire logic                  CMD_READY_O,
    input wire logic                  RSP_VALID_O,
    input wire calib_guard_pkg::rsp_t RSP_O,
    input wire logic                  CAL_START_O,
    input wire logic                  CAL_DONE_I,
    input wire logic                  CAL_FAIL_I,
    input wire logic [3:0]            CAL_SLOT_I,
    input wire logic                  CALIBRATING_O,
    input wire logic                  PROTECT_ENABLED_O,
    input wire logic                  NV_WRITE_O
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] op;
    logic       tk;
    logic       pw;
    assign op = CMD_I.op;
    assign tk = CMD_VALID_I && CMD_READY_O;
    assign pw = CMD_I.len == calib_guard_pkg::PASS_CHARS
        && CMD_I.text == calib_guard_pkg::PASSWORD;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ====
    // command outcomes
    property p_rst; !$past(RST_N_I) |-> !PROTECT_ENABLED_O; endproperty
    a_rst: assert property (p_rst) else $error("enabled after reset");
    property p_dis; tk && op == 3'h1 && pw |=> !PROTECT_ENABLED_O; endproperty
    a_dis: assert property (p_dis) else $error("disable ignored");
    property p_pw;
        tk && op < 3'h2 && !pw |=> $stable(PROTECT_ENABLED_O)
            && RSP_VALID_O && RSP_O.code == 9'h0dd;
    endproperty
    a_pw: assert property (p_pw) else $error("bad password taken");
    property p_st;
        tk && op == 3'h2 |=> RSP_O.value == {4'h0, $past(PROTECT_ENABLED_O)};
    endproperty
    a_st: assert property (p_st) else $error("state query wrong");
    property p_lock;
        tk && op == 3'h5 && !PROTECT_ENABLED_O |=> RSP_O.err && !CALIBRATING_O;
    endproperty
    a_lock: assert property (p_lock) else $error("cal not refused");
    property p_busy; CAL_START_O |-> CALIBRATING_O && !CMD_READY_O; endproperty
    a_busy: assert property (p_busy) else $error("not busy");
    // slots above 12 clamp, so only in-range slots are tied to a value
    property p_slot;
        CALIBRATING_O && CAL_DONE_I && CAL_FAIL_I && CAL_SLOT_I < 4'hd
            |=> RSP_VALID_O && RSP_O.value == {1'b0, $past(CAL_SLOT_I)} + 5'h0a;
    endproperty
    a_slot: assert property (p_slot) else $error("fail slot code");
    property p_ser;
        tk && op == 3'h3 && !PROTECT_ENABLED_O
            |=> !NV_WRITE_O && RSP_O.code == 9'h0dd;
    endproperty
    a_ser: assert property (p_ser) else $error("serial lock");
    c_cal: cover property (CALIBRATING_O && CAL_DONE_I);
    c_nv: cover property (NV_WRITE_O);
    c_en: cover property ($rose(PROTECT_ENABLED_O));
endmodule // calib_guard_chk
bind calib_guard_serial_store calib_guard_chk u_chk (
    .REF_CLK_I, .RST_N_I, .CMD_VALID_I, .CMD_I, .CMD_READY_O, .RSP_VALID_O,
    .RSP_O, .CAL_START_O, .CAL_DONE_I, .CAL_FAIL_I, .CAL_SLOT_I,
    .CALIBRATING_O, .PROTECT_ENABLED_O, .NV_WRITE_O
);
`default_nettype wire

// ===== bench/calib_guard_serial_store_bench.sv
// self-checking bench for the calibration guard block
`default_nettype none
module calib_guard_serial_store_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] PW = calib_guard_pkg::PASSWORD;
    logic                  clk, rst_n, cv, rdy, rv, cs, cd, cf, busy, en;
    logic                  kn, kp, ks, fr, nw;
    logic [3:0]            slot;
    logic [63:0]           nd;
    calib_guard_pkg::cmd_t cmd;
    calib_guard_pkg::rsp_t rsp, r;
    int                    fail_count, cmp_count, n, wn;
    calib_guard_serial_store u_dut (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(cv), .CMD_I(cmd),
        .CMD_READY_O(rdy), .RSP_VALID_O(rv), .RSP_O(rsp), .CAL_START_O(cs),
        .CAL_DONE_I(cd), .CAL_FAIL_I(cf), .CAL_SLOT_I(slot),
        .CALIBRATING_O(busy), .PROTECT_ENABLED_O(en), .KEY_NEXT_I(kn),
        .KEY_PREV_I(kp), .FILTER_ITEM_SHOWN_I(ks), .FILTER_RESTART_O(fr),
        .NV_WRITE_O(nw), .NV_DATA_O(nd));
    host_model u_host (.clk_i(clk), .ready_i(rdy), .rsp_valid_i(rv),
        .rsp_i(rsp), .cmd_valid_o(cv), .cmd_o(cmd));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // pulse counters for the restart and store strobes
    always @(posedge clk)
    begin
        n  <= n + int'(fr);
        wn <= wn + int'(nw);
    end
    // ====
    // calibration engine stand-in
    initial
    begin
        cd = 1'b0;
        forever
        begin
            @(posedge clk) #1;
            if (cs)
            begin
                repeat (5) @(posedge clk);
                #1 chk("busy", busy, 1'b1);
                cd = 1'b1;
                @(posedge clk) #1 cd = 1'b0;
                chk("busy end", busy, 1'b0);
            end
        end
    end
    task automatic chk(input string nm, input logic [63:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_locked();
        u_host.send(3'h2, 4'h0, '0, r);
        chk("state", r.value, 5'h00);
        u_host.send(3'h5, 4'h0, '0, r);
        chk("cal", r.err, 1'b1);
        chk("cal code", r.code, 9'h0cb);
        u_host.send(3'h3, 4'h3, 64'h323142, r);
        chk("ser lock", r.code, 9'h0dd);
        $display("locked done");
    endtask
    task automatic t_pass();
        u_host.send(3'h0, 4'h6, PW ^ 64'h1, r);
        chk("bad pw", r.code, 9'h0dd);
        u_host.send(3'h0, 4'h6, PW, r);
        u_host.send(3'h2, 4'h0, '0, r);
        chk("state", r.value, 5'h01);
        u_host.send(3'h1, 4'h6, PW ^ 64'h100, r);
        chk("bad dis", en, 1'b1);
        chk("bad dis code", r.code, 9'h0dd);
        $display("password done");
    endtask
    task automatic t_cal();
        for (int i = 0; i < 3; i++)
        begin
            cf = i > 0;
            slot = i == 1 ? 4'h0 : 4'hc;
            u_host.send(3'h5, 4'h0, '0, r);
            chk("cal", r.value, i == 0 ? 5'h00 : 5'h0a + slot);
        end
        $display("calibration done");
    endtask
    task automatic t_serial();
        int base;
        base = wn;
        u_host.send(3'h3, 4'h3, 64'h323162, r);
        chk("nv", nd, 64'h323142);
        u_host.send(3'h4, 4'h0, '0, r);
        chk("ser q", r.text, 64'h323142);
        u_host.send(3'h3, 4'h8, 64'h3635343332314261, r);
        chk("two letters", r.err, 1'b0);
        u_host.send(3'h3, 4'h3, 64'h424131, r);
        chk("digit first", r.code, 9'h0dc);
        u_host.send(3'h3, 4'h8, 64'h3736353433323141, r);
        chk("seven digits", r.code, 9'h0dc);
        u_host.send(3'h4, 4'h0, '0, r);
        chk("ser q2", r.text, 64'h3635343332314241);
        chk("nv pulses", wn - base, 2);
        $display("serial done");
    endtask
    task automatic t_dis();
        u_host.send(3'h1, 4'h6, PW, r);
        chk("dis", en, 1'b0);
        u_host.send(3'h5, 4'h0, '0, r);
        chk("cal off", r.err, 1'b1);
        chk("cal off code", r.code, 9'h0cb);
        $display("disable done");
    endtask
    task automatic t_filter();
        int base;
        base = n;
        u_host.send(3'h6, 4'h0, '0, r);
        repeat (2) @(posedge clk);
        #1 chk("cmd", n - base, 1);
        kn = 1'b1;
        kp = 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("no item", n - base, 1);
        ks = 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("chord", n - base, 2);
        $display("filter done");
    endtask
    initial
    begin
        {rst_n, cf, slot, kn, kp, ks} = '0;
        {fail_count, cmp_count} = '0;
        u_host.idle();
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        t_locked();
        t_pass();
        t_cal();
        t_serial();
        t_dis();
        t_filter();
        print_verdict();
    end
    initial
    begin
        #100us;
        fail_count++;
        print_verdict();
    end
endmodule // calib_guard_serial_store_bench
`default_nettype wire

// ===== bench/host_model.sv
// host partner issuing commands and collecting responses
`default_nettype none
module host_model (
    input  wire logic                  clk_i,
    input  wire logic                  ready_i,
    input  wire logic                  rsp_valid_i,
    input  wire calib_guard_pkg::rsp_t rsp_i,
    output logic                       cmd_valid_o,
    output calib_guard_pkg::cmd_t      cmd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // call once before the first command, so one process drives the port
    task automatic idle();
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    endtask
    // call just after an edge; one idle cycle follows every command
    task automatic send(input logic [2:0] op, input logic [3:0] ln,
                        input logic [63:0] tx,
                        output calib_guard_pkg::rsp_t r);
        int i;
        cmd_valid_o = 1'b1;
        cmd_o = {op, ln, tx};
        for (i = 0; i < 300 && !ready_i; i++)
            @(posedge clk_i) #1;
        @(posedge clk_i) #1;
        cmd_valid_o = 1'b0;
        cmd_o.text = ~tx;
        for (i = 0; i < 300 && !rsp_valid_i; i++)
            @(posedge clk_i) #1;
        r = rsp_valid_i ? rsp_i : 'x;
        @(posedge clk_i) #1;
    endtask
endmodule // host_model
`default_nettype wire

// ===== hdl/calib_guard_serial_store.sv
// command interpreter guarding calibration and storing the serial number
// ============================================================
// Summary of operation
// RULE_01 - a valid protect disable clears the enable state so later calibration is refused.
// RULE_02 - calibration without a prior valid enable is refused with an error.
// RULE_03 - a wrong password on enable or disable keeps the state and reports -221.
// RULE_04 - the state query answers 1 when enabled and 0 when disabled.
// RULE_05 - serial set writes storage and serial query returns the last stored text.
// RULE_06 - lower case letters are turned to upper case before storing.
// RULE_07 - a serial must be a letter, optional letter, up to six digits, else -220.
// RULE_08 - serial set while protection is in force is refused with -221.
// RULE_09 - the filter interval restarts on the command or on both scroll keys at the filter item.
// RULE_10 - the calibrating status bit is held while calibration runs.
// RULE_11 - calibration answers 0 on pass or 10 to 22 naming the failing slot.
// RULE_12 - after reset the enable state is cleared.
`default_nettype none
module calib_guard_serial_store (
    input  wire logic                  REF_CLK_I,
    input  wire logic                  RST_N_I,
    input  wire logic                  CMD_VALID_I,
    input  wire calib_guard_pkg::cmd_t CMD_I,
    output logic                       CMD_READY_O,
    output logic                       RSP_VALID_O,
    output calib_guard_pkg::rsp_t      RSP_O,
    output logic                       CAL_START_O,
    input  wire logic                  CAL_DONE_I,
    input  wire logic                  CAL_FAIL_I,
    input  wire logic [3:0]            CAL_SLOT_I,
    output logic                       CALIBRATING_O,
    output logic                       PROTECT_ENABLED_O,
    input  wire logic                  KEY_NEXT_I,
    input  wire logic                  KEY_PREV_I,
    input  wire logic                  FILTER_ITEM_SHOWN_I,
    output logic                       FILTER_RESTART_O,
    output logic                       NV_WRITE_O,
    output logic [8*calib_guard_pkg::SER_LEN-1:0] NV_DATA_O
);
    // ============================================================
    // helpers
    function automatic logic is_lower(input logic [7:0] c);
        return (c >= calib_guard_pkg::CHR_LA) && (c <= calib_guard_pkg::CHR_LZ);
    endfunction

    function automatic logic [7:0] to_upper(input logic [7:0] c);
        return is_lower(c) ? (c & ~calib_guard_pkg::CASE_BIT) : c;
    endfunction

    function automatic logic is_alpha(input logic [7:0] c);
        return (c >= calib_guard_pkg::CHR_UA) && (c <= calib_guard_pkg::CHR_UZ);
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        return (c >= calib_guard_pkg::CHR_D0) && (c <= calib_guard_pkg::CHR_D9);
    endfunction

    // ============================================================
    // pin synchronisers for the front-panel keys and display item
    logic [2:0] key_s1_reg;
    logic [2:0] key_s2_reg;
    logic       chord_prev_reg;
    logic       chord;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            key_s1_reg     <= 3'h0;
            key_s2_reg     <= 3'h0;
            chord_prev_reg <= 1'b0;
        end
        else
        begin
            key_s1_reg     <= {FILTER_ITEM_SHOWN_I, KEY_PREV_I, KEY_NEXT_I};
            key_s2_reg     <= key_s1_reg;
            chord_prev_reg <= chord;
        end
    end

    // one restart per press of the chord, not one per cycle held
    assign chord = &key_s2_reg; // RULE_09

    // ============================================================
    // serial text: upper-casing and format check
    logic [8*calib_guard_pkg::SER_LEN-1:0] up_text;
    logic                                  ser_ok;

    always_comb
    begin
        logic [3:0] digits;
        logic [3:0] start;
        digits = 4'h0;
        start  = 4'h1;
        for (int i = 0; i < calib_guard_pkg::SER_LEN; i++)
            up_text[8*i +: 8] = to_upper(CMD_I.text[8*i +: 8]); // RULE_06
        ser_ok = (CMD_I.len != 4'h0) && (CMD_I.len <= calib_guard_pkg::MAX_LEN)
                 && is_alpha(up_text[7:0]); // RULE_07
        if ((CMD_I.len > 4'h1) && is_alpha(up_text[15:8]))
            start = 4'h2;
        for (int i = 1; i < calib_guard_pkg::SER_LEN; i++)
        begin
            if ((4'(i) >= start) && (4'(i) < CMD_I.len))
            begin
                if (!is_digit(up_text[8*i +: 8]))
                    ser_ok = 1'b0;
                digits = digits + 4'h1;
            end
        end
        if (digits > calib_guard_pkg::MAX_DIGITS)
            ser_ok = 1'b0; // RULE_07
    end

    logic pass_ok;
    assign pass_ok = (CMD_I.len == calib_guard_pkg::PASS_CHARS)
                     && (CMD_I.text == calib_guard_pkg::PASSWORD);

    // ============================================================
    // command state machine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CAL  = 2'b10
    } state_t;

    state_t                                state_reg, state_next;
    logic                                  enabled_reg, enabled_next;
    logic [8*calib_guard_pkg::SER_LEN-1:0] serial_reg, serial_next;
    logic [3:0]                            ser_len_reg, ser_len_next;
    logic                                  rsp_valid_reg, rsp_valid_next;
    calib_guard_pkg::rsp_t                 rsp_reg, rsp_next;
    logic                                  cal_start_reg, cal_start_next;
    logic                                  restart_reg, restart_next;
    logic                                  nv_wr_reg, nv_wr_next;

    assign CMD_READY_O = (state_reg == ST_IDLE);

    always_comb
    begin
        state_next     = state_reg;
        enabled_next   = enabled_reg;
        serial_next    = serial_reg;
        ser_len_next   = ser_len_reg;
        rsp_valid_next = 1'b0;
        rsp_next       = rsp_reg;
        cal_start_next = 1'b0;
        restart_next   = chord && !chord_prev_reg; // RULE_09
        nv_wr_next     = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (CMD_VALID_I)
                begin
                    rsp_valid_next = 1'b1;
                    rsp_next       = '0;
                    unique case (CMD_I.op)
                        calib_guard_pkg::OP_PROTECT_ENABLE,
                        calib_guard_pkg::OP_PROTECT_DISABLE:
                        begin
                            if (pass_ok)
                                enabled_next = (CMD_I.op ==
                                    calib_guard_pkg::OP_PROTECT_ENABLE); // RULE_01
                            else
                            begin
                                rsp_next.err  = 1'b1; // RULE_03
                                rsp_next.code = calib_guard_pkg::ERR_CONFLICT;
                            end
                        end
                        calib_guard_pkg::OP_STATE_QUERY:
                        begin
                            rsp_next.has_int = 1'b1;
                            rsp_next.value   = {4'h0, enabled_reg}; // RULE_04
                        end
                        calib_guard_pkg::OP_SERIAL_SET:
                        begin
                            if (!enabled_reg)
                            begin
                                rsp_next.err  = 1'b1; // RULE_08
                                rsp_next.code = calib_guard_pkg::ERR_CONFLICT;
                            end
                            else if (!ser_ok)
                            begin
                                rsp_next.err  = 1'b1; // RULE_07
                                rsp_next.code = calib_guard_pkg::ERR_PARAM;
                            end
                            else
                            begin
                                serial_next  = up_text; // RULE_05
                                ser_len_next = CMD_I.len;
                                nv_wr_next   = 1'b1;
                            end
                        end
                        calib_guard_pkg::OP_SERIAL_QUERY:
                        begin
                            rsp_next.has_text = 1'b1; // RULE_05
                            rsp_next.len      = ser_len_reg;
                            rsp_next.text     = serial_reg;
                        end
                        calib_guard_pkg::OP_CALIBRATE:
                        begin
                            if (!enabled_reg)
                            begin
                                rsp_next.err  = 1'b1; // RULE_02
                                rsp_next.code = calib_guard_pkg::ERR_PROTECTED;
                            end
                            else
                            begin
                                rsp_valid_next = 1'b0;
                                cal_start_next = 1'b1;
                                state_next     = ST_CAL;
                            end
                        end
                        calib_guard_pkg::OP_FILTER_RESTART:
                            restart_next = 1'b1; // RULE_09
                        default:
                        begin
                            rsp_next.err  = 1'b1;
                            rsp_next.code = calib_guard_pkg::ERR_PARAM;
                        end
                    endcase
                end
            end
            ST_CAL:
            begin
                if (CAL_DONE_I)
                begin
                    rsp_valid_next   = 1'b1;
                    rsp_next         = '0;
                    rsp_next.has_int = 1'b1;
                    // slots past the last are clamped to the last code
                    if (CAL_FAIL_I)
                        rsp_next.value = calib_guard_pkg::SLOT_BASE +
                            ((5'(CAL_SLOT_I) > calib_guard_pkg::SLOT_LAST) ?
                             calib_guard_pkg::SLOT_LAST : 5'(CAL_SLOT_I)); // RULE_11
                    state_next = ST_IDLE;
                end
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_reg     <= ST_IDLE;
            enabled_reg   <= 1'b0; // RULE_12
            serial_reg    <= '0;
            ser_len_reg   <= 4'h0;
            rsp_valid_reg <= 1'b0;
            rsp_reg       <= '0;
            cal_start_reg <= 1'b0;
            restart_reg   <= 1'b0;
            nv_wr_reg     <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            enabled_reg   <= enabled_next;
            serial_reg    <= serial_next;
            ser_len_reg   <= ser_len_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_reg       <= rsp_next;
            cal_start_reg <= cal_start_next;
            restart_reg   <= restart_next;
            nv_wr_reg     <= nv_wr_next;
        end
    end

    assign RSP_VALID_O       = rsp_valid_reg;
    assign RSP_O             = rsp_reg;
    assign CAL_START_O       = cal_start_reg;
    assign CALIBRATING_O     = (state_reg == ST_CAL); // RULE_10
    assign PROTECT_ENABLED_O = enabled_reg;
    assign FILTER_RESTART_O  = restart_reg;
    assign NV_WRITE_O        = nv_wr_reg;
    assign NV_DATA_O         = serial_reg;
endmodule // calib_guard_serial_store
`default_nettype wire

// ===== include/calib_guard_pkg.sv
// shared constants and carriers for the calibration guard block
`default_nettype none
package calib_guard_pkg;
    localparam int SER_LEN = 8;
    localparam int PASS_LEN = 8;
    localparam logic [7:0] CHR_LA = 8'h61;
    localparam logic [7:0] CHR_LZ = 8'h7a;
    localparam logic [7:0] CHR_UA = 8'h41;
    localparam logic [7:0] CHR_UZ = 8'h5a;
    localparam logic [7:0] CHR_D0 = 8'h30;
    localparam logic [7:0] CHR_D9 = 8'h39;
    localparam logic [7:0] CASE_BIT = 8'h20;
    localparam logic [3:0] MAX_DIGITS = 4'h6;
    localparam logic [3:0] MAX_LEN = 4'h8;
    localparam logic [4:0] SLOT_BASE = 5'h0a;
    localparam logic [4:0] SLOT_LAST = 5'h0c;
    // error codes as positive magnitudes of the negative values
    localparam logic [8:0] ERR_NONE = 9'h000;
    localparam logic [8:0] ERR_PARAM = 9'h0dc;      // 220
    localparam logic [8:0] ERR_CONFLICT = 9'h0dd;   // 221
    localparam logic [8:0] ERR_PROTECTED = 9'h0cb;  // 203
    // fixed password, stored as text
    // char 0 sits in the low byte, as in every command text
    localparam logic [8*PASS_LEN-1:0] PASSWORD = 64'h0000_3031_3431_5856;
    localparam logic [3:0] PASS_CHARS = 4'h6;

    typedef enum logic [2:0] {
        OP_PROTECT_ENABLE  = 3'h0,
        OP_PROTECT_DISABLE = 3'h1,
        OP_STATE_QUERY     = 3'h2,
        OP_SERIAL_SET      = 3'h3,
        OP_SERIAL_QUERY    = 3'h4,
        OP_CALIBRATE       = 3'h5,
        OP_FILTER_RESTART  = 3'h6
    } op_t;

    typedef struct packed {
        op_t                     op;
        logic [3:0]              len;
        logic [8*SER_LEN-1:0]    text;   // char 0 in bits 7:0
    } cmd_t;

    typedef struct packed {
        logic                    err;
        logic [8:0]              code;
        logic                    has_int;
        logic [4:0]              value;
        logic                    has_text;
        logic [3:0]              len;
        logic [8*SER_LEN-1:0]    text;
    } rsp_t;
endpackage
`default_nettype wire
